// ===== core/spdh_params.svh
/*
  Constants for the single-pin debug host: register map, field
  positions, protocol codes and timing counts.
  Assumes a 40 MHz core clock and an Avalon-MM byte-addressed map.
*/
`ifndef SPDH_PARAMS_SVH
`define SPDH_PARAMS_SVH
`define SPDH_REG_CTRL 8'h00
`define SPDH_REG_BAUD 8'h04
`define SPDH_REG_CMD 8'h08
`define SPDH_REG_STATUS 8'h0C
`define SPDH_TXBUF_SEL 2'h1
`define SPDH_RXBUF_SEL 2'h2
`define SPDH_CTRL_START 0
`define SPDH_CTRL_ENSEQ 1
`define SPDH_CTRL_DISHOLD 2
`define SPDH_CTRL_RSTHOLD 3
`define SPDH_STS_DONE 1
`define SPDH_STS_CRCERR 2
`define SPDH_STS_FMTERR 3
`define SPDH_STS_TMO 4
`define SPDH_BUF_DEPTH 16
`define SPDH_SYNC 8'h55
`define SPDH_CMD_DISABLE 8'h07
`define SPDH_CMD_SPLIT 8'h08
`define SPDH_RESP_ACK 8'h40
`define SPDH_CRC_POLY 16'h8408
`define SPDH_CRC_INIT 16'h0000
`define SPDH_BAUD_RST 16'h0028
`define SPDH_BAUD_MIN 16'h0004
`define SPDH_CLK_HZ 40000000
`define SPDH_ENABLE_BAUD_HZ 1000
`define SPDH_HOLD_DIS_MS 100
`define SPDH_HOLD_RST_MS 20
`define SPDH_RESP_TMO_MS 200
`define SPDH_ENABLE_BIT_CYC (`SPDH_CLK_HZ / `SPDH_ENABLE_BAUD_HZ)
`define SPDH_HOLD_DIS_CYC (`SPDH_CLK_HZ / 1000 * `SPDH_HOLD_DIS_MS)
`define SPDH_HOLD_RST_CYC (`SPDH_CLK_HZ / 1000 * `SPDH_HOLD_RST_MS)
`define SPDH_RESP_TMO_CYC (`SPDH_CLK_HZ / 1000 * `SPDH_RESP_TMO_MS)
`endif

// ===== core/spdh_pkg.sv
/*
  Types for the single-pin debug host: engine states and the
  carriers for the Avalon-MM slave and the debug line.
  Assumes spdh_params.svh holds all numeric constants except the state codes set here.
*/
`default_nettype none
package spdh_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HOLD = 5'h02,
    ST_TX = 5'h04,
    ST_RXWAIT = 5'h08,
    ST_RXBIT = 5'h10
  } spdh_state_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } spdh_avs_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } spdh_avs_rsp_t;
  typedef struct packed {
    logic lineOut;
    logic lineOe_n;
  } spdh_pin_t;
endpackage
`default_nettype wire

// ===== core/spdh_master.sv
/*
  External master for a single-pin debug slave sharing a reset pin.
  Software fills command, length and data over Avalon-MM; the block
  frames, sends, then receives and checks the response packet.
  Assumes the line and split receive pin are synchronous to core_clk
  and that the line is pulled high when nobody drives it.
*/
// Summary of operation
// - Start, eight data LSB first, stop
// - Host starts every exchange, picks bit rate
// - Sync, code, optional length, data, CRC
// - Bit7 means length; commands keep bit6 clear
// - CRC reflected 0x8408, zero start value
// - Enable: one 0x55 character at 1 kHz
// - Hold low 100 ms disables slave
// - Hold low 20 ms resets slave
// - Bit rate at most quarter of oscillator
// - Service bus accesses naturally aligned
// - Codes for guard, disable, split, reset
`include "spdh_params.svh"
`default_nettype none
module spdh_master #(
  parameter int unsigned ENABLE_BIT_CYC = `SPDH_ENABLE_BIT_CYC,
  parameter int unsigned HOLD_DIS_CYC = `SPDH_HOLD_DIS_CYC,
  parameter int unsigned HOLD_RST_CYC = `SPDH_HOLD_RST_CYC,
  parameter int unsigned RESP_TMO_CYC = `SPDH_RESP_TMO_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire spdh_pkg::spdh_avs_req_t avs,
  output var spdh_pkg::spdh_avs_rsp_t avsRsp,
  input wire logic lineIn,
  input wire logic splitRxIn,
  output var spdh_pkg::spdh_pin_t line
);
  import spdh_pkg::*;

  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `SPDH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [9:0] frame(input logic [7:0] b);
    return {1'b1, b, 1'b0};
  endfunction

  spdh_state_t state;
  logic accessDone;
  logic [31:0] readData;
  logic [15:0] baudDiv;
  logic [7:0] cmdByte;
  logic [15:0] cmdLen;
  logic [7:0] txBuf [`SPDH_BUF_DEPTH];
  logic [7:0] rxBuf [`SPDH_BUF_DEPTH];
  logic [22:0] timer;
  logic [3:0] bitCnt;
  logic [9:0] shift;
  logic [7:0] rxShift;
  logic [16:0] byteIdx;
  logic [15:0] crc;
  logic [7:0] crcHi;
  logic enFrame;
  logic split;
  logic [7:0] lastCmd;
  logic [7:0] respByte;
  logic [15:0] respLen;
  logic done, crcErr, fmtErr, tmo;
  logic [7:0] nextTxByte;
  logic [16:0] txTotal, rxTotal, dIdx;
  logic txLast, rxLast, rxPin, busWr, busy;

  assign busWr = avs.write & accessDone;
  assign busy = (state != ST_IDLE);
  assign txTotal = cmdByte[7] ? 17'(cmdLen) + 17'h6 : 17'h4;
  assign rxTotal = respByte[7] ? 17'(respLen) + 17'h6 : 17'h4;
  assign txLast = (byteIdx + 17'h1 == txTotal);
  assign rxLast = respByte[7] ? (byteIdx >= 17'h4 && byteIdx + 17'h1 ==
                  rxTotal) : (byteIdx == 17'h3);
  assign dIdx = byteIdx - 17'h4;
  // Split mode moves only the slave's answers off the shared line
  assign rxPin = split ? splitRxIn : lineIn;

  // One wait state: request seen, answer at the following edge
  always_comb begin
    avsRsp.readdata = readData;
    avsRsp.waitrequest = (avs.read | avs.write) & ~accessDone;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      accessDone <= 1'b0;
    end else begin
      accessDone <= (avs.read | avs.write) & ~accessDone;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readData <= 32'h0000_0000;
    end else if (avs.read && !accessDone) begin
      case (avs.address)
        `SPDH_REG_BAUD: readData <= {16'h0000, baudDiv};
        `SPDH_REG_CMD: readData <= {8'h00, cmdLen, cmdByte};
        `SPDH_REG_STATUS: readData <= {respLen, respByte, 2'h0, split,
                                       tmo, fmtErr, crcErr, done, busy};
        default: begin
          if (avs.address[7:6] == `SPDH_TXBUF_SEL) begin
            readData <= {24'h000000, txBuf[avs.address[5:2]]};
          end else if (avs.address[7:6] == `SPDH_RXBUF_SEL) begin
            readData <= {24'h000000, rxBuf[avs.address[5:2]]};
          end else begin
            readData <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // Setup registers only change while idle, so a frame never tears
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baudDiv <= `SPDH_BAUD_RST;
      cmdByte <= 8'h00;
      cmdLen <= 16'h0000;
      for (int i = 0; i < `SPDH_BUF_DEPTH; i++) begin
        txBuf[i] <= 8'h00;
      end
    end else if (busWr && !busy) begin
      case (avs.address)
        `SPDH_REG_BAUD: begin
          // Host picks the rate; floor keeps the bit timer sane
          baudDiv <= (avs.writedata[15:0] < `SPDH_BAUD_MIN) ?
                     `SPDH_BAUD_MIN : avs.writedata[15:0];
        end
        `SPDH_REG_CMD: begin
          cmdByte <= avs.writedata[7:0];
          cmdLen <= avs.writedata[23:8];
        end
        default: begin
          if (avs.address[7:6] == `SPDH_TXBUF_SEL) begin
            txBuf[avs.address[5:2]] <= avs.writedata[7:0];
          end
        end
      endcase
    end
  end

  // Data beyond the buffer depth repeats the buffer contents
  // Payload goes out verbatim; software keeps addresses aligned
  always_comb begin
    nextTxByte = crc[7:0];
    if (byteIdx == 17'h0) begin
      nextTxByte = {cmdByte[7], 1'b0, cmdByte[5:0]};
    end else if (cmdByte[7] && byteIdx == 17'h1) begin
      nextTxByte = cmdLen[15:8];
    end else if (cmdByte[7] && byteIdx == 17'h2) begin
      nextTxByte = cmdLen[7:0];
    end else if (byteIdx + 17'h3 < txTotal) begin
      nextTxByte = txBuf[byteIdx[3:0] - 4'h3];
    end else if (byteIdx + 17'h3 == txTotal) begin
      nextTxByte = crc[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      timer <= 23'h0;
      bitCnt <= 4'h0;
      shift <= 10'h3FF;
      rxShift <= 8'h00;
      byteIdx <= 17'h0;
      crc <= `SPDH_CRC_INIT;
      crcHi <= 8'h00;
      enFrame <= 1'b0;
      split <= 1'b0;
      lastCmd <= 8'h00;
      respByte <= 8'h00;
      respLen <= 16'h0000;
      done <= 1'b0;
      crcErr <= 1'b0;
      fmtErr <= 1'b0;
      tmo <= 1'b0;
      for (int i = 0; i < `SPDH_BUF_DEPTH; i++) begin
        rxBuf[i] <= 8'h00;
      end
    end else begin
      // Write-one clears; later set assignments win in the same cycle
      if (busWr && avs.address == `SPDH_REG_STATUS) begin
        if (avs.writedata[`SPDH_STS_DONE]) done <= 1'b0;
        if (avs.writedata[`SPDH_STS_CRCERR]) crcErr <= 1'b0;
        if (avs.writedata[`SPDH_STS_FMTERR]) fmtErr <= 1'b0;
        if (avs.writedata[`SPDH_STS_TMO]) tmo <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          bitCnt <= 4'h0;
          byteIdx <= 17'h0;
          crc <= `SPDH_CRC_INIT;
          if (busWr && avs.address == `SPDH_REG_CTRL) begin
            if (avs.writedata[`SPDH_CTRL_START]) begin
              shift <= frame(`SPDH_SYNC);
              timer <= 23'(baudDiv - 16'h1);
              enFrame <= 1'b0;
              lastCmd <= cmdByte;
              respByte <= 8'h00;
              respLen <= 16'h0000;
              state <= ST_TX;
            end else if (avs.writedata[`SPDH_CTRL_ENSEQ]) begin
              // Lone 0x55 at 1 kHz arms the slave; no packet follows
              shift <= frame(`SPDH_SYNC);
              timer <= 23'(ENABLE_BIT_CYC - 1);
              enFrame <= 1'b1;
              split <= 1'b0;
              state <= ST_TX;
            end else if (avs.writedata[`SPDH_CTRL_DISHOLD]) begin
              shift <= 10'h000;
              timer <= 23'(HOLD_DIS_CYC - 1);
              split <= 1'b0;
              state <= ST_HOLD;
            end else if (avs.writedata[`SPDH_CTRL_RSTHOLD]) begin
              shift <= 10'h000;
              timer <= 23'(HOLD_RST_CYC - 1);
              split <= 1'b0;
              state <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (timer != 23'h0) begin
            timer <= timer - 23'h1;
          end else begin
            shift <= 10'h3FF;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_TX: begin
          if (timer != 23'h0) begin
            timer <= timer - 23'h1;
          end else begin
            timer <= enFrame ? 23'(ENABLE_BIT_CYC - 1) :
                               23'(baudDiv - 16'h1);
            if (bitCnt != 4'h9) begin
              shift <= {1'b1, shift[9:1]};
              bitCnt <= bitCnt + 4'h1;
            end else if (enFrame || txLast) begin
              // Let go of the line the moment the stop bit ends
              timer <= 23'(RESP_TMO_CYC - 1);
              bitCnt <= 4'h0;
              byteIdx <= 17'h0;
              done <= enFrame;
              state <= enFrame ? ST_IDLE : ST_RXWAIT;
            end else begin
              shift <= frame(nextTxByte);
              bitCnt <= 4'h0;
              byteIdx <= byteIdx + 17'h1;
              if (byteIdx + 17'h3 < txTotal) begin
                crc <= crcByte(crc, nextTxByte);
              end
            end
          end
        end
        ST_RXWAIT: begin
          // Slave's guard time falls inside this wait
          if (!rxPin) begin
            timer <= 23'(baudDiv[15:1] - 15'h1);
            bitCnt <= 4'h0;
            state <= ST_RXBIT;
          end else if (timer != 23'h0) begin
            timer <= timer - 23'h1;
          end else begin
            tmo <= 1'b1;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_RXBIT: begin
          if (timer != 23'h0) begin
            timer <= timer - 23'h1;
          end else if (bitCnt == 4'h0 && rxPin) begin
            timer <= 23'(RESP_TMO_CYC - 1);
            state <= ST_RXWAIT;
          end else if (bitCnt != 4'h9) begin
            timer <= 23'(baudDiv - 16'h1);
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt != 4'h0) rxShift <= {rxPin, rxShift[7:1]};
          end else begin
            timer <= 23'(RESP_TMO_CYC - 1);
            state <= ST_RXWAIT;
            byteIdx <= byteIdx + 17'h1;
            if (!rxPin) fmtErr <= 1'b1;
            if (byteIdx == 17'h0) begin
              if (rxShift != `SPDH_SYNC) fmtErr <= 1'b1;
            end else if (byteIdx == 17'h1) begin
              respByte <= rxShift;
              crc <= crcByte(`SPDH_CRC_INIT, rxShift);
              if (!rxShift[6]) fmtErr <= 1'b1;
            end else if (rxLast) begin
              // All-zero CRC field means the sender skipped it
              if ({crcHi, rxShift} != 16'h0000 &&
                  {crcHi, rxShift} != crc) begin
                crcErr <= 1'b1;
              end
              if (respByte == `SPDH_RESP_ACK) begin
                if (lastCmd == `SPDH_CMD_SPLIT) split <= 1'b1;
                if (lastCmd == `SPDH_CMD_DISABLE) split <= 1'b0;
              end
              done <= 1'b1;
              state <= ST_IDLE;
            end else if (byteIdx + 17'h2 == rxTotal &&
                         (!respByte[7] || byteIdx >= 17'h4)) begin
              crcHi <= rxShift;
            end else begin
              crc <= crcByte(crc, rxShift);
              if (byteIdx == 17'h2) respLen[15:8] <= rxShift;
              else if (byteIdx == 17'h3) respLen[7:0] <= rxShift;
              else if (dIdx < 17'(`SPDH_BUF_DEPTH)) begin
                rxBuf[dIdx[3:0]] <= rxShift;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Line is actively driven only while sending or holding it low
  always_comb begin
    line.lineOut = shift[0];
    line.lineOe_n = ~(state == ST_TX || state == ST_HOLD);
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence sReqNew;
    (avs.read | avs.write) && !accessDone;
  endsequence
  sequence sAnswer;
    avsRsp.waitrequest ##1 !avsRsp.waitrequest;
  endsequence
  sequence sLastStop;
    state == ST_TX && bitCnt == 4'h9 && timer == 23'h0 &&
    (enFrame || txLast);
  endsequence

  a_idle_released: assert property (state == ST_IDLE |->
      line.lineOe_n && line.lineOut)
    else $error("line driven while idle");
  a_hold_low: assert property (state == ST_HOLD |->
      !line.lineOe_n && !line.lineOut)
    else $error("hold does not drive low");
  a_cmd_bit_six: assert property (state == ST_TX && !enFrame &&
      byteIdx == 17'h1 && bitCnt == 4'h7 |-> !line.lineOut)
    else $error("command sent with bit 6 set");
  a_start_stop_bits: assert property (state == ST_TX |->
      (bitCnt != 4'h0 || !line.lineOut) &&
      (bitCnt != 4'h9 || line.lineOut))
    else $error("bad start or stop level");
  a_bus_answer: assert property (sReqNew |-> sAnswer)
    else $error("bus answer not after one wait");
  a_release_stop: assert property (sLastStop |=> line.lineOe_n)
    else $error("line held after last stop");
  a_enable_rate: assert property (state == ST_TX && enFrame &&
      timer == 23'h0 && bitCnt != 4'h9 |=>
      timer == 23'(ENABLE_BIT_CYC - 1))
    else $error("enable bit period wrong");
  a_hold_length: assert property (state == ST_IDLE &&
      busWr && avs.address == `SPDH_REG_CTRL &&
      avs.writedata[3:0] == 4'h8 |=>
      state == ST_HOLD && timer == 23'(HOLD_RST_CYC - 1))
    else $error("reset hold length wrong");
endmodule
`default_nettype wire

// ===== sim/spdh_slave_model.sv
/*
  Behavioural model of the single-pin debug slave behind the host.
  Assumes lineLvl is the resolved, pulled-up shared line and that
  core_clk stands in for the slave's own fast oscillator.
*/
`include "spdh_params.svh"
`default_nettype none
module spdh_slave_model #(
  parameter int RST_LOW = 80,
  parameter int DIS_LOW = 160
) (
  input wire logic core_clk,
  input wire logic lineLvl,
  input wire logic [1:0] faultMode,
  output logic slaveOut,
  output logic slaveOe_n,
  output logic splitOut,
  output logic active,
  output logic sysRst,
  output logic [7:0] guard,
  output logic [7:0] rstCount,
  output logic [15:0] tune
);
  timeunit 1ns;
  timeprecision 1ps;
  logic split = 1'h0;
  logic rstPulse = 1'h0;
  int unsigned bitCyc = 40;
  assign sysRst = rstPulse | (!active && !lineLvl);
  function automatic logic [15:0] crcb(input logic [15:0] c,
                                       input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? (c >> 1) ^ `SPDH_CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic rxByte(output logic [7:0] b);
    wait (lineLvl === 1'h0);
    repeat (bitCyc / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(posedge core_clk);
      b[i] = lineLvl;
    end
    repeat (bitCyc) @(posedge core_clk);
  endtask
  task automatic txByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      if (split) splitOut <= f[i];
      else slaveOut <= f[i];
      slaveOe_n <= split;
      repeat (bitCyc) @(posedge core_clk);
    end
  endtask
  task automatic pulseRst();
    rstPulse = 1'h1;
    rstCount++;
    @(posedge core_clk);
    rstPulse = 1'h0;
  endtask
  initial begin
    logic [7:0] cmd, b, d0, rsp;
    logic [15:0] len, crc, got;
    int unsigned n;
    slaveOut = 1'h1;
    slaveOe_n = 1'h1;
    splitOut = 1'h1;
    active = 1'h0;
    guard = 8'h80;
    rstCount = 8'h0;
    tune = 16'h0;
    forever begin
      @(negedge lineLvl);
      n = 0;
      while (lineLvl === 1'h0 && n < DIS_LOW) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= RST_LOW) begin
        wait (lineLvl === 1'h1);
        if (n >= DIS_LOW) begin
          pulseRst();
          active = 1'h0;
          split = 1'h0;
        end else if (active) begin
          split = 1'h0;
          guard = 8'h80;
        end
        continue;
      end
      // Time the sync over eight bit periods, fall to fifth fall
      for (int k = 0; k < 4; k++) begin
        while (lineLvl !== 1'h0) begin
          @(posedge core_clk);
          n++;
        end
        while (k < 3 && lineLvl === 1'h0) begin
          @(posedge core_clk);
          n++;
        end
      end
      tune = 16'(n - 1);
      bitCyc = tune / 8;
      wait (lineLvl === 1'h1);
      if (!active) begin
        active = 1'h1;
        guard = 8'h80;
        continue;
      end
      rxByte(cmd);
      crc = crcb(`SPDH_CRC_INIT, cmd);
      len = 16'h0;
      d0 = 8'h0;
      if (cmd[7]) begin
        rxByte(len[15:8]);
        rxByte(len[7:0]);
        crc = crcb(crcb(crc, len[15:8]), len[7:0]);
      end
      for (int i = 0; i < len; i++) begin
        rxByte(b);
        crc = crcb(crc, b);
        if (i == 0) d0 = b;
      end
      rxByte(got[15:8]);
      rxByte(got[7:0]);
      rsp = ((got == 16'h0 || got == crc) && !cmd[6] && (cmd inside
        {[8'h01:8'h08], [8'h80:8'h84]})) ? 8'h40 : 8'h41;
      // Service bus runs at the oscillator rate here, so the count is 6
      if (rsp == 8'h40 && cmd == 8'h05) rsp = 8'hC5;
      // Silence is only commanded to provoke the host's timeout
      if (faultMode == 2'h3) continue;
      repeat (guard * bitCyc) @(posedge core_clk);
      crc = crcb(`SPDH_CRC_INIT, rsp);
      if (rsp[7]) crc = crcb(crcb(crcb(crcb(crc, 8'h0), 8'h2), 8'h0), 8'h6);
      if (faultMode == 2'h1) crc = crc ^ 16'h1;
      if (faultMode == 2'h2) crc = 16'h0;
      txByte(`SPDH_SYNC);
      txByte(rsp);
      if (rsp[7]) begin
        txByte(8'h0);
        txByte(8'h2);
        txByte(8'h0);
        txByte(8'h6);
      end
      txByte(crc[15:8]);
      txByte(crc[7:0]);
      slaveOe_n <= 1'h1;
      if (rsp == 8'h40) begin
        if (cmd == 8'h07) active = 1'h0;
        if (cmd == 8'h07) split = 1'h0;
        if (cmd == 8'h08) split = 1'h1;
        if (cmd == 8'h83) pulseRst();
        if (cmd == 8'h84 && len != 0) guard = d0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/*
  Self-checking bench for the single-pin debug host over Avalon-MM.
  Assumes spdh_pkg, spdh_master and spdh_slave_model compiled first.
*/
`include "spdh_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spdh_pkg::*;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  spdh_avs_req_t avs = '0;
  spdh_avs_rsp_t avsRsp;
  spdh_pin_t line;
  logic lineLvl, slaveOut, slaveOe_n, splitOut, active;
  logic [1:0] faultMode = 2'h0;
  logic [7:0] guard, rstCount, rc;
  logic [15:0] tune;
  logic [31:0] s;
  int unsigned miscompares = 0;
  int unsigned nChecks = 0;
  int unsigned cycles = 0;
  // Pulled-up shared line: low wins from whichever side drives
  assign lineLvl = (line.lineOe_n | line.lineOut) & (slaveOe_n | slaveOut);
  spdh_master #(
    .ENABLE_BIT_CYC(40),
    .HOLD_DIS_CYC(200),
    .HOLD_RST_CYC(100),
    .RESP_TMO_CYC(10000)
  ) u_spdh_master (
    .core_clk(core_clk),
    .rstn(rstn),
    .avs(avs),
    .avsRsp(avsRsp),
    .lineIn(lineLvl),
    .splitRxIn(splitOut),
    .line(line)
  );
  spdh_slave_model u_spdh_slave_model (
    .core_clk(core_clk),
    .lineLvl(lineLvl),
    .faultMode(faultMode),
    .slaveOut(slaveOut),
    .slaveOe_n(slaveOe_n),
    .splitOut(splitOut),
    .active(active),
    .sysRst(),
    .guard(guard),
    .rstCount(rstCount),
    .tune(tune)
  );
  always #12.5 core_clk = ~core_clk;
  task automatic end_of_test();
    if (miscompares == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs <= '{read: !w, write: w, address: a, writedata: d};
    forever begin
      @(posedge core_clk);
      if (avsRsp.waitrequest === 1'h0) break;
    end
    q = avsRsp.readdata;
    avs <= '0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic op(input logic [31:0] c, input logic [3:0] ctl);
    wr(`SPDH_REG_STATUS, 32'h1E);
    wr(`SPDH_REG_CMD, c);
    wr(`SPDH_REG_CTRL, {28'h0, ctl});
    s = 32'h0;
    while (s[`SPDH_STS_DONE] !== 1'h1)
      bus(1'h0, `SPDH_REG_STATUS, 32'h0, s);
  endtask
  function automatic logic [31:0] st(input logic [7:0] r,
                                     input logic [5:0] f);
    return {16'h0, r, 2'h0, f};
  endfunction
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    rdc(`SPDH_REG_BAUD, {16'h0, `SPDH_BAUD_RST});
    rdc(`SPDH_REG_CMD, 32'h0);
    rdc(`SPDH_REG_STATUS, 32'h0);
    rdc(`SPDH_REG_CTRL, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'h0);
    chk({31'h0, active}, 32'h0);
    op(32'h0, 4'h2);
    chk({26'h0, s[5:0]}, 32'h2);
    chk({31'h0, active}, 32'h1);
    wr(`SPDH_REG_BAUD, 32'h2);
    rdc(`SPDH_REG_BAUD, 32'h4);
    wr(8'h40, 32'h2);
    op(32'h184, 4'h1);
    chk(s, st(8'h40, 6'h2));
    chk({16'h0, tune}, 32'h20);
    chk({24'h0, guard}, 32'h2);
    op(32'h41, 4'h1);
    chk(s, st(8'h40, 6'h2));
    op(32'h09, 4'h1);
    chk(s, st(8'h41, 6'h2));
    op(32'h05, 4'h1);
    chk(s, 32'h0002_C502);
    rdc(8'h80, 32'h0);
    rdc(8'h84, 32'h6);
    faultMode <= 2'h1;
    op(32'h01, 4'h1);
    chk(s, st(8'h40, 6'h6));
    faultMode <= 2'h2;
    op(32'h01, 4'h1);
    chk(s, st(8'h40, 6'h2));
    faultMode <= 2'h3;
    op(32'h01, 4'h1);
    chk({26'h0, s[5:0]}, 32'h12);
    faultMode <= 2'h0;
    op(32'h08, 4'h1);
    chk(s, st(8'h40, 6'h22));
    op(32'h01, 4'h1);
    chk(s, st(8'h40, 6'h22));
    rc = rstCount;
    op(32'h83, 4'h1);
    chk(s, st(8'h40, 6'h22));
    chk({24'h0, rstCount}, {24'h0, rc + 8'h1});
    op(32'h07, 4'h1);
    chk(s, st(8'h40, 6'h2));
    chk({31'h0, active}, 32'h0);
    op(32'h0, 4'h2);
    chk({31'h0, active}, 32'h1);
    op(32'h184, 4'h1);
    chk({24'h0, guard}, 32'h2);
    op(32'h0, 4'h8);
    chk({26'h0, s[5:0]}, 32'h2);
    chk({24'h0, guard}, 32'h80);
    chk({31'h0, active}, 32'h1);
    rc = rstCount;
    op(32'h0, 4'h4);
    chk({31'h0, active}, 32'h0);
    chk({24'h0, rstCount}, {24'h0, rc + 8'h1});
    end_of_test();
  end
endmodule
`default_nettype wire
